// [ibs_params.svh]
/*
  constants for the incoming bus sampler: register offsets, field positions,
  reset values and byte position counts.
  assumes inclusion by bare name from the sampler and framer ends.
*/
`ifndef IBS_PARAMS_SVH
`define IBS_PARAMS_SVH

// ==========================================================
// register offsets (byte addresses on the bus)
`define IBS_ADDR_CTRL 8'h00
`define IBS_ADDR_STAT 8'h04
`define IBS_ADDR_ERRS 8'h08

// ==========================================================
// control fields
`define IBS_CTRL_MARKER_EN 0
`define IBS_CTRL_POS_SEL 1
`define IBS_CTRL_INC_FP 2
`define IBS_CTRL_INC_PL 3
`define IBS_CTRL_ODD 4
`define IBS_CTRL_RESET 5'h00

// ==========================================================
// status fields
`define IBS_STAT_PARERR 0
`define IBS_STAT_MFSEEN 1

// ==========================================================
// byte positions counted in payload bytes after the first tributary's J1
`define IBS_POS_THIRD 10'h003
`define IBS_POS_H4 10'h1B3
`define IBS_POS_MAX 10'h3FF
`define IBS_H4_LAST_PHASE 2'h3

`endif

// [ibs_pkg.sv]
/*
  shared types and the parity helper for the incoming bus sampler.
  assumes nothing of its surroundings.
*/
package ibs_pkg;

  // ==========================================================
  // framer end states
  typedef enum logic [1:0] {FR_EMPTY, FR_BYTE, FR_HI, FR_LO} ibs_fr_state_t;

  // ==========================================================
  // one received byte with its flags
  typedef struct packed {
    logic framePulse;
    logic payload;
    logic multiframe;
    logic parityError;
    logic [7:0] data;
  } ibs_word_t;

  // ==========================================================
  // parity line value for a beat
  function automatic logic ibs_parity(input logic [7:0] d, input logic fp, input logic pl,
                                      input logic incFp, input logic parity_include_payload, input logic odd);
    ibs_parity = (^d) ^ (incFp & fp) ^ (parity_include_payload & pl) ^ odd;
  endfunction

endpackage

// [ibs_if.sv]
/*
  incoming tributary stream bus between the upstream framer and the sampler.
  assumes both ends share mclk; clkEn is the system or nibble clock enable.
*/
`timescale 1ns/100ps
`default_nettype none

interface ibs_if;
  logic widthSelect;
  logic clkEn;
  logic [7:0] data;
  logic framePulse;
  logic payloadActive;
  logic marker;
  logic parityLine;
  logic busReady;

  modport framer (
    output widthSelect, clkEn, data, framePulse, payloadActive, marker, parityLine,
    input busReady
  );
  modport sampler (
    input widthSelect, clkEn, data, framePulse, payloadActive, marker, parityLine,
    output busReady
  );
endinterface

`default_nettype wire

// [ibs_pair_buf.sv]
/*
  two-entry buffer with valid and ready on both sides.
  assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module ibs_pair_buf #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  logic [W-1:0] mem [0:1];
  logic [W-1:0] next_mem [0:1];
  logic wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [1:0] count, next_count;
  logic push, pop;

  // ==========================================================
  // flags
  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // ==========================================================
  // next values
  always_comb begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (push) begin
      next_mem[wrPtr] = inData;
      next_wrPtr = ~wrPtr;
    end
    if (pop) begin
      next_rdPtr = ~rdPtr;
    end
    case ({push, pop})
      2'b10: next_count = count + 2'h1;
      2'b01: next_count = count - 2'h1;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end
endmodule

`default_nettype wire

// [ibs_framer_end.sv]
/*
  upstream framer end: drives the incoming bus a byte or two nibbles at a time.
  assumes the sampler's busReady stalls it; one clock, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ibs_params.svh"

module ibs_framer_end (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus
  ibs_if.framer bus,
  // mode and parity setup
  input wire logic byteMode,
  input wire logic includeFramePulse,
  input wire logic includePayload,
  input wire logic parityOdd,
  // user source
  input wire logic srcValid,
  output logic srcReady,
  input wire logic [7:0] srcData,
  input wire logic srcFramePulse,
  input wire logic srcPayload,
  input wire logic srcMarker
);
  ibs_pkg::ibs_fr_state_t state, next_state;
  logic [7:0] busData, next_busData;
  logic [3:0] loNib, next_loNib;
  logic busFp, busPl, busMk, busPar;
  logic next_busFp, next_busPl, next_busMk, next_busPar;
  logic advance;

  // ==========================================================
  // pins
  assign bus.widthSelect = byteMode;
  assign bus.data = busData;
  assign bus.framePulse = busFp;
  assign bus.payloadActive = busPl;
  assign bus.marker = busMk;
  assign bus.parityLine = busPar;
  assign bus.clkEn = (state != ibs_pkg::FR_EMPTY) & bus.busReady;
  assign advance = bus.clkEn;
  assign srcReady = (state == ibs_pkg::FR_EMPTY);

  // ==========================================================
  // next values
  always_comb begin
    next_state = state;
    next_busData = busData;
    next_loNib = loNib;
    next_busFp = busFp;
    next_busPl = busPl;
    next_busMk = busMk;
    next_busPar = busPar;
    case (state)
      ibs_pkg::FR_EMPTY: begin
        if (srcValid) begin
          next_busFp = srcFramePulse;
          next_busPl = srcPayload;
          next_busMk = srcMarker;
          next_loNib = srcData[3:0];
          if (byteMode) begin
            next_state = ibs_pkg::FR_BYTE;
            next_busData = srcData;
            next_busPar = ibs_pkg::ibs_parity(srcData, srcFramePulse, srcPayload,
                                              includeFramePulse, includePayload, parityOdd);
          end else begin
            next_state = ibs_pkg::FR_HI;
            next_busData = {4'h0, srcData[7:4]};
            next_busPar = ibs_pkg::ibs_parity({4'h0, srcData[7:4]}, srcFramePulse, srcPayload,
                                              includeFramePulse, includePayload, parityOdd);
          end
        end
      end
      ibs_pkg::FR_HI: begin
        if (advance) begin
          next_state = ibs_pkg::FR_LO;
          next_busData = {4'h0, loNib};
          next_busFp = 1'b0;
          next_busPl = 1'b0;
          next_busMk = 1'b0;
          next_busPar = ibs_pkg::ibs_parity({4'h0, loNib}, 1'b0, 1'b0,
                                            includeFramePulse, includePayload, parityOdd);
        end
      end
      ibs_pkg::FR_BYTE, ibs_pkg::FR_LO: begin
        if (advance) begin
          next_state = ibs_pkg::FR_EMPTY;
        end
      end
      default: next_state = ibs_pkg::FR_EMPTY;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ibs_pkg::FR_EMPTY;
      busData <= 8'h00;
      loNib <= 4'h0;
      busFp <= 1'b0;
      busPl <= 1'b0;
      busMk <= 1'b0;
      busPar <= 1'b0;
    end else begin
      state <= next_state;
      busData <= next_busData;
      loNib <= next_loNib;
      busFp <= next_busFp;
      busPl <= next_busPl;
      busMk <= next_busMk;
      busPar <= next_busPar;
    end
  end
endmodule

`default_nettype wire

// [ibs_sampler.sv]
/*
  incoming bus sampler: byte or nibble capture, parity check, multiframe
  detection, registers on classic wishbone, output through a two-entry buffer.
  assumes the framer pulses clkEn only while busReady is high.

  // Summary of operation
  // - marker input used only when enabled
  // - disabled marker: boundaries from H4 byte
  // - select bit picks H4 or third after J1
  // - marker accepted only at selected position
  // - byte mode samples marker every system beat
  // - nibble mode: marker in upper nibble slot
  // - byte mode parity over eight data bits
  // - nibble mode parity over low four bits
  // - include bits add frame pulse, payload
  // - sense bit high odd, low even
  // - parity line sampled per mode's clock
  // - byte mode bit 7 first, bit 0 last
  // - nibble mode upper nibble first, bit 3 leads
  // - nibble mode ignores upper four bits
  // - payload marks payload bytes or upper nibbles
  // - generated clock is nibble clock halved
*/
`timescale 1ns/100ps
`default_nettype none
`include "ibs_params.svh"

module ibs_sampler (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus
  ibs_if.sampler bus,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // received stream
  output logic outValid,
  input wire logic outReady,
  output logic [7:0] outData,
  output logic outFramePulse,
  output logic outPayload,
  output logic outMultiframe,
  output logic outParityError,
  // clocking
  output logic generatedSystemClock
);
  logic [4:0] ctrl, next_ctrl;
  logic [1:0] stat, next_stat;
  logic [15:0] errCount, next_errCount;
  logic ack, next_ack;
  logic [31:0] rdData, next_rdData;
  logic lowPending, next_lowPending;
  logic [3:0] hiNib, next_hiNib;
  logic hiFp, hiPl, hiMk, hiErr, next_hiFp, next_hiPl, next_hiMk, next_hiErr;
  logic [9:0] pos, next_pos;
  logic posValid, next_posValid;
  logic generated_system_clock, next_generated_system_clock;
  logic byteMode, beat, hiSlot, beatErr, byteDone, atThird, atH4, mfHit;
  logic [7:0] selData;
  logic beatFp, beatPl;
  ibs_pkg::ibs_word_t word, outWord;
  logic bufReady;
  logic wbReq, wbWr;

  // ==========================================================
  // beat capture
  assign byteMode = bus.widthSelect;
  assign beat = bus.clkEn;
  assign hiSlot = byteMode | ~lowPending | bus.framePulse;
  assign selData = byteMode ? bus.data : {4'h0, bus.data[3:0]};
  assign beatFp = hiSlot & bus.framePulse;
  assign beatPl = hiSlot & bus.payloadActive;
  assign beatErr = bus.parityLine != ibs_pkg::ibs_parity(selData, beatFp, beatPl,
      ctrl[`IBS_CTRL_INC_FP], ctrl[`IBS_CTRL_INC_PL], ctrl[`IBS_CTRL_ODD]);
  assign byteDone = beat & (byteMode | ~hiSlot);

  // ==========================================================
  // assembled byte
  always_comb begin
    word.data = byteMode ? bus.data : {hiNib, bus.data[3:0]};
    word.framePulse = byteMode ? bus.framePulse : hiFp;
    word.payload = byteMode ? bus.payloadActive : hiPl;
    word.parityError = byteMode ? beatErr : (hiErr | beatErr);
    word.multiframe = mfHit;
  end

  // ==========================================================
  // byte position and multiframe
  always_comb begin
    next_pos = pos;
    next_posValid = posValid;
    if (byteDone) begin
      if (word.framePulse & word.payload) begin
        next_pos = 10'h000;
        next_posValid = 1'b1;
      end else if (word.payload & posValid & (pos != `IBS_POS_MAX)) begin
        next_pos = pos + 10'h001;
      end
    end
    atThird = byteDone & word.payload & posValid & ~word.framePulse & (next_pos == `IBS_POS_THIRD);
    atH4 = byteDone & word.payload & posValid & ~word.framePulse & (next_pos == `IBS_POS_H4);
    if (ctrl[`IBS_CTRL_MARKER_EN]) begin
      mfHit = (byteMode ? bus.marker : hiMk) &
              (ctrl[`IBS_CTRL_POS_SEL] ? atH4 : atThird);
    end else begin
      mfHit = atH4 & (word.data[1:0] == `IBS_H4_LAST_PHASE);
    end
  end

  // ==========================================================
  // nibble holding and generated clock
  always_comb begin
    next_lowPending = lowPending;
    next_hiNib = hiNib;
    next_hiFp = hiFp;
    next_hiPl = hiPl;
    next_hiMk = hiMk;
    next_hiErr = hiErr;
    next_generated_system_clock = generated_system_clock;
    if (beat & ~byteMode) begin
      next_generated_system_clock = ~generated_system_clock;
      if (hiSlot) begin
        next_lowPending = 1'b1;
        next_hiNib = bus.data[3:0];
        next_hiFp = bus.framePulse;
        next_hiPl = bus.payloadActive;
        next_hiMk = bus.marker;
        next_hiErr = beatErr;
      end else begin
        next_lowPending = 1'b0;
      end
    end
    if (byteMode) begin
      next_lowPending = 1'b0;
    end
  end

  // ==========================================================
  // output buffer
  ibs_pair_buf #(.W(12)) outBuf (
    .mclk(mclk),
    .rst(rst),
    .inValid(byteDone),
    .inReady(bufReady),
    .inData(word),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outWord)
  );
  assign bus.busReady = bufReady;
  assign outData = outWord.data;
  assign outFramePulse = outWord.framePulse;
  assign outPayload = outWord.payload;
  assign outMultiframe = outWord.multiframe;
  assign outParityError = outWord.parityError;
  assign generatedSystemClock = generated_system_clock;

  // ==========================================================
  // wishbone registers
  assign wbReq = wbCyc & wbStb & ~ack;
  assign wbWr = wbReq & wbWe & wbSel[0];
  assign wbAck = ack;
  assign wbDatO = rdData;

  always_comb begin
    next_ack = wbReq;
    next_ctrl = ctrl;
    next_stat = stat;
    next_errCount = errCount;
    next_rdData = 32'h0000_0000;
    if (wbWr & (wbAdr == `IBS_ADDR_CTRL)) begin
      next_ctrl = wbDatI[4:0];
    end
    if (wbWr & (wbAdr == `IBS_ADDR_STAT)) begin
      next_stat = stat & ~wbDatI[1:0];
    end
    if (wbWr & (wbAdr == `IBS_ADDR_ERRS)) begin
      next_errCount = 16'h0000;
    end
    if (beat & beatErr) begin
      next_stat[`IBS_STAT_PARERR] = 1'b1;
      if (next_errCount != 16'hFFFF) begin
        next_errCount = next_errCount + 16'h0001;
      end
    end
    if (byteDone & mfHit) begin
      next_stat[`IBS_STAT_MFSEEN] = 1'b1;
    end
    if (wbReq & ~wbWe) begin
      case (wbAdr)
        `IBS_ADDR_CTRL: next_rdData = {27'h0, ctrl};
        `IBS_ADDR_STAT: next_rdData = {30'h0, stat};
        `IBS_ADDR_ERRS: next_rdData = {16'h0, errCount};
        default: next_rdData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= `IBS_CTRL_RESET;
      stat <= 2'h0;
      errCount <= 16'h0000;
      ack <= 1'b0;
      rdData <= 32'h0000_0000;
      lowPending <= 1'b0;
      hiNib <= 4'h0;
      hiFp <= 1'b0;
      hiPl <= 1'b0;
      hiMk <= 1'b0;
      hiErr <= 1'b0;
      pos <= 10'h000;
      posValid <= 1'b0;
      generated_system_clock <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      stat <= next_stat;
      errCount <= next_errCount;
      ack <= next_ack;
      rdData <= next_rdData;
      lowPending <= next_lowPending;
      hiNib <= next_hiNib;
      hiFp <= next_hiFp;
      hiPl <= next_hiPl;
      hiMk <= next_hiMk;
      hiErr <= next_hiErr;
      pos <= next_pos;
      posValid <= next_posValid;
      generated_system_clock <= next_generated_system_clock;
    end
  end
endmodule

`default_nettype wire

// [ibs_bus_checker.sv]
/*
  assertions on the incoming bus between the framer and sampler ends.
  assumes one clock, mclk, and synchronous active high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module ibs_bus_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus
  input wire logic widthSelect,
  input wire logic clkEn,
  input wire logic [7:0] data,
  input wire logic framePulse,
  input wire logic payloadActive,
  input wire logic marker,
  input wire logic parityLine,
  input wire logic busReady
);
  // ==========================================================
  // nibble phase, high between upper and lower beat
  logic phase;
  logic next_phase;
  always_comb begin
    next_phase = phase;
    if (widthSelect) begin
      next_phase = 1'b0;
    end else if (clkEn) begin
      next_phase = !phase;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // bus properties
  a_beat_ready: assert property (clkEn |-> busReady)
    else $error("beat without ready");
  a_upper_ignored: assert property (!widthSelect && clkEn |-> data[7:4] == 4'h0)
    else $error("upper bits set in nibble mode");
  a_lower_flags: assert property (phase && clkEn |-> !framePulse && !payloadActive && !marker)
    else $error("flags in lower nibble");
  a_pair_follow: assert property (phase && busReady |-> clkEn)
    else $error("lower nibble late");
  a_byte_pulse: assert property (widthSelect && clkEn |=> !clkEn)
    else $error("byte beat too long");
  a_lower_gap: assert property (phase && clkEn |=> !clkEn)
    else $error("no gap after lower nibble");
  a_mode_hold: assert property (phase |-> $stable(widthSelect))
    else $error("mode changed inside a byte");
  a_pair_span: assert property ($rose(phase) |-> ##[1:64] !phase)
    else $error("nibble pair never closed");
endmodule

`default_nettype wire

// [incoming_bus_sampler_tb.sv]
/*
  self-checking bench for framer and sampler ends joined by the bus.
  assumes the design files and ibs_params.svh are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ibs_params.svh"

module incoming_bus_sampler_tb;
  logic mclk, rst, byteMode, includeFramePulse, includePayload, parityOdd;
  logic srcValid, srcReady, srcFramePulse, srcPayload, srcMarker;
  logic [7:0] srcData, outData;
  logic wbCyc, wbStb, wbWe, wbAck, outValid, outReady, generatedSystemClock, lastGsc;
  logic outFramePulse, outPayload, outMultiframe, outParityError;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, r;
  int badCount, checkCount, gscCount, cnt, pos;
  ibs_pkg::ibs_word_t got[$];

  // ==========================================================
  // design
  ibs_if ibs_if_inst ();
  ibs_framer_end ibs_framer_end_inst (.mclk, .rst, .bus(ibs_if_inst), .byteMode,
    .includeFramePulse, .includePayload, .parityOdd, .srcValid, .srcReady, .srcData,
    .srcFramePulse, .srcPayload, .srcMarker);
  ibs_sampler ibs_sampler_inst (.mclk, .rst, .bus(ibs_if_inst), .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .outValid, .outReady, .outData,
    .outFramePulse, .outPayload, .outMultiframe, .outParityError, .generatedSystemClock);
  ibs_bus_checker ibs_bus_checker_inst (.mclk, .rst,
    .widthSelect(ibs_if_inst.widthSelect), .clkEn(ibs_if_inst.clkEn),
    .data(ibs_if_inst.data), .framePulse(ibs_if_inst.framePulse),
    .payloadActive(ibs_if_inst.payloadActive), .marker(ibs_if_inst.marker),
    .parityLine(ibs_if_inst.parityLine), .busReady(ibs_if_inst.busReady));

  // ==========================================================
  // clock, monitor, watchdog
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      got.push_back({outFramePulse, outPayload, outMultiframe, outParityError, outData});
    end
    if (generatedSystemClock !== lastGsc) begin
      gscCount++;
    end
    lastGsc <= generatedSystemClock;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    badCount++;
    wrapUp();
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] din);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= din;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) badCount++;
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic send(input logic [7:0] d, input logic fp, input logic pl, input logic mk);
    srcValid <= 1'b1;
    srcData <= d;
    srcFramePulse <= fp;
    srcPayload <= pl;
    srcMarker <= mk;
    do @(posedge mclk); while (srcReady !== 1'b1);
    srcValid <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic waitN(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 400) begin
      @(posedge mclk);
      k++;
    end
    if (got.size() < n) badCount++;
  endtask
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_regs();
    wb(1'b0, `IBS_ADDR_CTRL, 32'h0);
    check(r, 32'h0);
    wb(1'b1, `IBS_ADDR_CTRL, 32'h1F);
    wb(1'b0, `IBS_ADDR_CTRL, 32'h0);
    check(r, 32'h1F);
    wb(1'b1, 8'h0C, 32'hFF);
    wb(1'b0, 8'h0C, 32'h0);
    check(r, 32'h0);
    $display("test regs done");
  endtask
  task automatic test_parity(input logic m);
    int i;
    logic e;
    byteMode <= m;
    wb(1'b1, `IBS_ADDR_ERRS, 32'h0);
    gscCount = 0;
    for (i = 0; i < 8; i++) begin
      wb(1'b1, `IBS_ADDR_CTRL, 32'(i) << 2);
      got.delete();
      send(8'h5A, 1'b1, 1'b1, 1'b0);
      waitN(1);
      e = (i[0] ^ i[1] ^ i[2]) | (!m & i[2]);
      check(32'(got[0]), {20'h0, 3'h6, e, 8'h5A});
    end
    check(32'(gscCount), m ? 32'h0 : 32'h10);
    wb(1'b0, `IBS_ADDR_STAT, 32'h0);
    check(32'(r[0]), 32'h1);
    wb(1'b0, `IBS_ADDR_ERRS, 32'h0);
    check(r, m ? 32'h4 : 32'h8);
    wb(1'b1, `IBS_ADDR_STAT, 32'h3);
    {includeFramePulse, includePayload, parityOdd} <= 3'h7;
    wb(1'b1, `IBS_ADDR_CTRL, 32'h1C);
    got.delete();
    send(8'h5A, 1'b1, 1'b1, 1'b0);
    waitN(1);
    check(32'(got[0]), 32'hC5A);
    {includeFramePulse, includePayload, parityOdd} <= 3'h0;
    $display("test parity done");
  endtask
  task automatic test_frame(input logic m, input logic [4:0] ctl, input logic [7:0] d,
                            input int eCnt, input int ePos);
    int k;
    byteMode <= m;
    wb(1'b1, `IBS_ADDR_CTRL, {27'h0, ctl});
    got.delete();
    send(8'h00, 1'b1, 1'b1, 1'b1);
    for (k = 1; k < 436; k++) send(d, 1'b0, 1'b1, 1'b1);
    waitN(436);
    cnt = 0;
    pos = -1;
    for (k = 0; k < got.size(); k++) begin
      if (got[k].multiframe) begin
        cnt++;
        pos = k;
      end
    end
    check(32'(cnt), 32'(eCnt));
    check(32'(pos), 32'(ePos));
    wb(1'b0, `IBS_ADDR_STAT, 32'h0);
    check(32'(r[1]), 32'(eCnt != 0));
    wb(1'b1, `IBS_ADDR_STAT, 32'h3);
    $display("test frame done");
  endtask
  task automatic test_stall();
    int k;
    outReady <= 1'b0;
    got.delete();
    fork
      for (k = 0; k < 4; k++) send(8'h10 + 8'(k), 1'b0, 1'b1, 1'b0);
      begin
        repeat (30) @(posedge mclk);
        check(32'(ibs_if_inst.busReady), 32'h0);
        outReady <= 1'b1;
      end
    join
    waitN(4);
    for (k = 0; k < 4; k++) check(32'(got[k].data), 32'h10 + 32'(k));
    $display("test stall done");
  endtask

  initial begin
    rst = 1'b1;
    byteMode = 1'b1;
    {includeFramePulse, includePayload, parityOdd} = 3'h0;
    {srcValid, srcFramePulse, srcPayload, srcMarker, srcData} = 12'h000;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} = 43'h0;
    wbSel = 4'hF;
    outReady = 1'b1;
    lastGsc = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    test_regs();
    test_parity(1'b1);
    test_parity(1'b0);
    test_frame(1'b1, 5'h01, 8'h03, 1, 3);
    test_frame(1'b1, 5'h03, 8'h00, 1, 435);
    test_frame(1'b1, 5'h00, 8'h03, 1, 435);
    test_frame(1'b1, 5'h00, 8'h00, 0, -1);
    test_frame(1'b0, 5'h01, 8'h03, 1, 3);
    byteMode <= 1'b1;
    test_stall();
    wrapUp();
  end
endmodule

`default_nettype wire
